/* File: dv/cpu_power_mode_control_monitor.sv */
// checker for the power mode sequencer ports
`timescale 1ns/1ps
`include "pwr_mode_map.vh"

module cpu_power_mode_control_monitor (
    input wire mclk,
    input wire reset_n,
    input wire quiesce_ack,
    input wire ext_interrupt,
    input wire quiesce_request,
    input wire [`NUM_UNITS-1:0] unit_clk_en,
    input wire snoop_enable,
    input wire timer_enable,
    input wire dcache_enable,
    input wire core_run,
    input wire [2:0] power_state
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);

    property p_sleep_off;
        power_state == 3'h7 |-> !snoop_enable && !timer_enable && !dcache_enable && !core_run;
    endproperty
    a_sleep_off: assert property (p_sleep_off) else $error("unit alive in sleep");
    property p_doze_alive;
        power_state == 3'h2 |-> snoop_enable && timer_enable;
    endproperty
    a_doze_alive: assert property (p_doze_alive) else $error("doze lost snoop or timer");
    property p_nap_timer;
        power_state == 3'h5 |-> timer_enable && !core_run;
    endproperty
    a_nap_timer: assert property (p_nap_timer) else $error("nap timer off or core running");
    property p_nap_snoop;
        (power_state == 3'h5 && quiesce_ack) [*4] |-> !snoop_enable;
    endproperty
    a_nap_snoop: assert property (p_nap_snoop) else $error("snoop while ack held");
    property p_quiesce_request_held;
        power_state >= 3'h3 |-> quiesce_request;
    endproperty
    a_quiesce_request_held: assert property (p_quiesce_request_held) else $error("quiesce request missing");
    property p_no_hop;
        ($past(power_state) inside {3'h2, 3'h5, 3'h7}) && power_state != $past(power_state) |-> power_state == 3'h0;
    endproperty
    a_no_hop: assert property (p_no_hop) else $error("left low power not to full on");
    property p_doze_entry;
        $rose(power_state == 3'h2) |-> $past(power_state) == 3'h1 && $past(power_state, 4) == 3'h1;
    endproperty
    a_doze_entry: assert property (p_doze_entry) else $error("doze entered too early");
    property p_sleep_wake;
        power_state == 3'h7 && ext_interrupt |=> power_state == 3'h0 && core_run && !quiesce_request;
    endproperty
    a_sleep_wake: assert property (p_sleep_wake) else $error("slow wake from sleep");
    property p_gate_sleep;
        (power_state == 3'h7) [*2] |-> unit_clk_en == 4'h0;
    endproperty
    a_gate_sleep: assert property (p_gate_sleep) else $error("unit clock on in sleep");
    c_doze: cover property (power_state == 3'h2);
    c_nap_snoop: cover property (power_state == 3'h5 && snoop_enable);
    c_sleep_wake: cover property (power_state == 3'h7 ##1 power_state == 3'h0);
endmodule

bind cpu_power_mode_control cpu_power_mode_control_monitor i_cpu_power_mode_control_monitor (.mclk, .reset_n,
    .quiesce_ack, .ext_interrupt, .quiesce_request, .unit_clk_en, .snoop_enable, .timer_enable,
    .dcache_enable, .core_run, .power_state);

/* File: dv/cpu_power_mode_control_tb.sv */
// self-checking bench for the power mode sequencer
`timescale 1ns/1ps

module cpu_power_mode_control_tb;
    reg mclk = 1'h0;
    reg reset_n = 1'h0;
    reg [3:0] addr = 4'h0;
    reg [31:0] wdata = 32'h0;
    reg wr_stb = 1'h0;
    reg rd_stb = 1'h0;
    reg [8:0] wk = 9'h0;
    reg [3:0] unit_demand = 4'h0;
    reg snoop_want = 1'h0;
    reg [3:0] ack_delay = 4'h1;
    wire [31:0] rdata;
    wire bus_clk_tick, quiesce_ack, quiesce_request, snoop_enable, timer_enable, dcache_enable, core_run;
    wire [3:0] unit_clk_en;
    wire [2:0] power_state;
    integer miscompares = 0;
    integer comparisons = 0;
    integer m, i;

    cpu_power_mode_control i_cpu_power_mode_control (.mclk, .reset_n, .ce(1'h1), .addr, .wdata, .wr_stb,
        .rd_stb, .rdata, .bus_clk_tick, .quiesce_ack, .hard_reset_in(wk[0]), .soft_reset_in(wk[1]),
        .ext_interrupt(wk[2]), .system_mgmt_interrupt(wk[3]), .machine_check_input(wk[4]),
        .decrementer_event(wk[5]), .perf_monitor_event(wk[6]), .machine_check_interrupt(wk[7]),
        .thermal_event(wk[8]), .unit_demand, .quiesce_request, .unit_clk_en, .snoop_enable,
        .timer_enable, .dcache_enable, .core_run, .power_state);
    system_logic_model i_system_logic_model (.mclk, .reset_n, .quiesce_request, .snoop_want, .ack_delay,
        .quiesce_ack, .bus_clk_tick);

    initial forever #4 mclk = ~mclk;

    task summarize;
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task chk(input [31:0] got, input [31:0] exp);
        comparisons = comparisons + 1;
        if (got !== exp) begin
            miscompares = miscompares + 1;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task wr(input [3:0] a, input [31:0] d);
        @(posedge mclk);
        addr <= a;
        wdata <= d;
        wr_stb <= 1'h1;
        @(posedge mclk);
        wr_stb <= 1'h0;
    endtask
    task rd(input [3:0] a, input [31:0] exp);
        @(posedge mclk);
        addr <= a;
        rd_stb <= 1'h1;
        @(posedge mclk);
        rd_stb <= 1'h0;
        #1;
        chk(rdata, exp);
    endtask
    task wait_for(input [2:0] s, input sn);
        integer n;
        n = 0;
        while (!(power_state === s && snoop_enable === sn) && n < 200) begin
            @(posedge mclk);
            #1;
            n = n + 1;
        end
        if (n == 200) begin
            miscompares = miscompares + 1;
            $display("ERROR %0t: timeout in state %h", $time, power_state);
            summarize;
        end
    endtask
    task pulse(input integer k);
        @(posedge mclk);
        wk[k] <= 1'h1;
        @(posedge mclk);
        wk[k] <= 1'h0;
        @(posedge mclk);
        #1;
    endtask
    task t_regs;
        rd(4'h0, 32'h0);
        wr(4'h0, 32'hFFFFFFFF);
        rd(4'h0, 32'h00000F00);
        rd(4'hF, 32'h0);
        wr(4'h1, 32'h00040000);
        repeat (12) @(posedge mclk);
        #1;
        chk(power_state, 3'h0);
        wr(4'h1, 32'h0);
        wr(4'h0, 32'h0);
        $display("test regs done");
    endtask
    task t_gate;
        wr(4'h0, 32'h00000800);
        unit_demand <= 4'h5;
        repeat (3) @(posedge mclk);
        #1;
        chk(unit_clk_en, 4'h5);
        rd(4'h3, 32'h5);
        repeat (8) @(posedge mclk);
        rd(4'h2, 32'h00000080);
        wr(4'h0, 32'h0);
        repeat (3) @(posedge mclk);
        #1;
        chk(unit_clk_en, 4'hF);
        rd(4'h2, 32'h00000080);
        $display("test gate done");
    endtask
    // every wake source tried in doze, nap and sleep; slow ack for sleep
    task t_modes;
        reg [8:0] mask;
        reg [2:0] fs;
        for (m = 0; m < 3; m = m + 1) begin
            mask = (m == 0) ? 9'h1FF : (m == 1) ? 9'h03F : 9'h01F;
            fs = (m == 0) ? 3'h2 : (m == 1) ? 3'h5 : 3'h7;
            ack_delay <= (m == 2) ? 4'h9 : 4'h1;
            for (i = 0; i < 9; i = i + 1) begin
                wr(4'h0, 32'h100 << m);
                wr(4'h1, 32'h00040000);
                wait_for(fs, m == 0);
                chk(timer_enable, m != 2);
                chk(dcache_enable, m == 0);
                pulse(i);
                chk(power_state, mask[i] ? 3'h0 : fs);
                if (!mask[i])
                    pulse(2);
                chk(quiesce_request, 1'h0);
                chk(core_run, 1'h1);
            end
        end
        $display("test modes done");
    endtask
    task t_nap_snoop;
        ack_delay <= 4'h1;
        wr(4'h0, 32'h200);
        wr(4'h1, 32'h00040000);
        wait_for(3'h5, 1'h0);
        rd(4'h2, 32'h00000065);
        snoop_want <= 1'h1;
        repeat (20) @(posedge mclk);
        #1;
        chk(snoop_enable, 1'h0);
        wait_for(3'h5, 1'h1);
        rd(4'h2, 32'h000000A5);
        @(posedge mclk);
        snoop_want <= 1'h0;
        wait_for(3'h5, 1'h0);
        pulse(5);
        chk(power_state, 3'h0);
        $display("test nap snoop done");
    endtask

    initial begin
        repeat (12) @(posedge mclk);
        reset_n <= 1'h1;
        t_regs;
        t_gate;
        t_modes;
        t_nap_snoop;
        summarize;
    end
endmodule

/* File: dv/system_logic_model.sv */
// system logic model: quiesce handshake and bus clock ticks
`timescale 1ns/1ps

module system_logic_model (
    input wire mclk,
    input wire reset_n,
    input wire quiesce_request,
    input wire snoop_want,
    input wire [3:0] ack_delay,
    output reg quiesce_ack,
    output reg bus_clk_tick
);
    reg [3:0] wait_q;
    reg [1:0] div_q;

    // bus clock runs free at a quarter of the core rate
    always @(posedge mclk) begin
        if (!reset_n) begin
            div_q <= 2'h0;
            bus_clk_tick <= 1'h0;
        end else begin
            div_q <= div_q + 2'h1;
            bus_clk_tick <= (div_q == 2'h3);
        end
    end

    // a wanted snoop drops ack at once; the bench holds it long enough
    always @(posedge mclk) begin
        if (!reset_n || !quiesce_request || snoop_want) begin
            wait_q <= 4'h0;
            quiesce_ack <= 1'h0;
        end else if (wait_q >= ack_delay) begin
            quiesce_ack <= 1'h1;
        end else begin
            wait_q <= wait_q + 4'h1;
        end
    end
endmodule

/* File: hw/cpu_power_mode_control.v */
// power state sequencer: full on, doze, nap, sleep with quiesce handshake
`timescale 1ns/1ps
`include "pwr_mode_map.vh"

module cpu_power_mode_control (
    mclk,
    reset_n,
    ce,
    addr,
    wdata,
    wr_stb,
    rd_stb,
    rdata,
    bus_clk_tick,
    quiesce_ack,
    hard_reset_in,
    soft_reset_in,
    ext_interrupt,
    system_mgmt_interrupt,
    machine_check_input,
    decrementer_event,
    perf_monitor_event,
    thermal_event,
    machine_check_interrupt,
    unit_demand,
    quiesce_request,
    unit_clk_en,
    snoop_enable,
    timer_enable,
    dcache_enable,
    core_run,
    power_state
);
    input wire mclk;
    input wire reset_n;
    input wire ce;
    input wire [`ADDR_W-1:0] addr;
    input wire [31:0] wdata;
    input wire wr_stb;
    input wire rd_stb;
    output reg [31:0] rdata;
    input wire bus_clk_tick;
    input wire quiesce_ack;
    input wire hard_reset_in;
    input wire soft_reset_in;
    input wire ext_interrupt;
    input wire system_mgmt_interrupt;
    input wire machine_check_input;
    input wire decrementer_event;
    input wire perf_monitor_event;
    input wire thermal_event;
    input wire machine_check_interrupt;
    input wire [`NUM_UNITS-1:0] unit_demand;
    output reg quiesce_request;
    output wire [`NUM_UNITS-1:0] unit_clk_en;
    output reg snoop_enable;
    output reg timer_enable;
    output reg dcache_enable;
    output reg core_run;
    output reg [2:0] power_state;

    localparam [2:0] ST_FULL_ON = 3'h0;
    localparam [2:0] ST_DOZE_ENTRY = 3'h1;
    localparam [2:0] ST_DOZE = 3'h2;
    localparam [2:0] ST_QUIESCE = 3'h3;
    localparam [2:0] ST_NAP_ENTRY = 3'h4;
    localparam [2:0] ST_NAP = 3'h5;
    localparam [2:0] ST_SLEEP_ENTRY = 3'h6;
    localparam [2:0] ST_SLEEP = 3'h7;

    reg [31:0] impl_config_reg;
    reg [31:0] machine_state_reg;
    reg pow_prev_q;
    reg [2:0] state_q;
    reg [2:0] state_d;
    reg [`CNT_W-1:0] cnt_q;
    reg [`CNT_W-1:0] cnt_d;
    reg target_sleep_q;
    reg target_sleep_d;
    reg [`BUS_CNT_W-1:0] ack_low_cnt_q;
    reg nap_snoop_q;

    wire cfg_wr = wr_stb && (addr == `ADDR_IMPL_CONFIG);
    wire msr_wr = wr_stb && (addr == `ADDR_MACHINE_STATE);
    wire pow_bit = machine_state_reg[`BIT_POW];
    wire pow_rise = pow_bit && !pow_prev_q;
    wire sel_doze = impl_config_reg[`BIT_DOZE];
    wire sel_nap = impl_config_reg[`BIT_NAP];
    wire sel_sleep = impl_config_reg[`BIT_SLEEP];

    // wake groups, narrowest first; each state takes a narrower subset
    wire wake_reset = hard_reset_in || soft_reset_in;
    wire wake_async = ext_interrupt || system_mgmt_interrupt || machine_check_input;
    wire wake_sleep = wake_reset || wake_async;
    wire wake_nap = wake_sleep || decrementer_event;
    wire wake_doze = wake_nap || perf_monitor_event || thermal_event || machine_check_interrupt;

    function is_one_hot3;
        input [2:0] v;
        begin
            is_one_hot3 = (v == 3'h1) || (v == 3'h2) || (v == 3'h4);
        end
    endfunction

    // state groups used by the output decode; the next-state logic does not use them
    function in_doze_group;
        input [2:0] s;
        begin
            in_doze_group = (s == ST_DOZE_ENTRY) || (s == ST_DOZE);
        end
    endfunction

    function in_nap_group;
        input [2:0] s;
        begin
            in_nap_group = (s == ST_NAP_ENTRY) || (s == ST_NAP);
        end
    endfunction

    function in_sleep_group;
        input [2:0] s;
        begin
            in_sleep_group = (s == ST_SLEEP_ENTRY) || (s == ST_SLEEP);
        end
    endfunction

    // the handshake stays up from the quiesce wait until a wake
    function asks_quiesce;
        input [2:0] s;
        begin
            asks_quiesce = (s == ST_QUIESCE) || in_nap_group(s) || in_sleep_group(s);
        end
    endfunction

    // entry count-up to ENTRY_DELAY shared by the doze, nap and sleep entry states
    function entry_done;
        input [`CNT_W-1:0] c;
        begin
            entry_done = (c == `ENTRY_DELAY);
        end
    endfunction

    function [`CNT_W-1:0] entry_step;
        input [`CNT_W-1:0] c;
        begin
            entry_step = c + 1'b1;
        end
    endfunction

    // a wake aborts an entry or the handshake too; an event seen while still in full on, as in the pow_rise cycle, is dropped
    function wake_for;
        input [2:0] s;
        input tgt_sleep;
        input wd;
        input wn;
        input ws;
        begin
            case (s)
                ST_DOZE_ENTRY, ST_DOZE: wake_for = wd;
                ST_QUIESCE: wake_for = tgt_sleep ? ws : wn;
                ST_NAP_ENTRY, ST_NAP: wake_for = wn;
                ST_SLEEP_ENTRY, ST_SLEEP: wake_for = ws;
                default: wake_for = 1'b0;
            endcase
        end
    endfunction

    wire wake_now = wake_for(state_q, target_sleep_q, wake_doze, wake_nap, wake_sleep);

    // register file
    always @(posedge mclk) begin
        if (!reset_n) begin
            impl_config_reg <= `IMPL_CONFIG_RESET;
            machine_state_reg <= `MACHINE_STATE_RESET;
            pow_prev_q <= 1'b0;
        end else if (ce) begin
            pow_prev_q <= pow_bit;
            if (cfg_wr) begin
                impl_config_reg <= wdata & `IMPL_CONFIG_MASK;
            end
            // a wake clears the request bit so the core resumes in full on
            if (state_q != ST_FULL_ON && state_d == ST_FULL_ON) begin
                machine_state_reg[`BIT_POW] <= 1'b0;
            end else if (msr_wr) begin
                machine_state_reg <= wdata & `MACHINE_STATE_MASK;
            end
        end
    end

    always @(posedge mclk) begin
        if (!reset_n) begin
            rdata <= 32'h00000000;
        end else if (ce) begin
            rdata <= 32'h00000000;
            if (rd_stb) begin
                case (addr)
                    `ADDR_IMPL_CONFIG: rdata <= impl_config_reg;
                    `ADDR_MACHINE_STATE: rdata <= machine_state_reg;
                    `ADDR_STATUS: rdata <= {24'h000000, nap_snoop_q, quiesce_ack, quiesce_request, 2'h0, state_q};
                    `ADDR_UNIT_DEMAND: rdata <= {28'h0000000, unit_clk_en};
                    default: rdata <= 32'h00000000;
                endcase
            end
        end
    end

    // snoop window in nap: ack low for enough bus clocks
    always @(posedge mclk) begin
        if (!reset_n) begin
            ack_low_cnt_q <= {`BUS_CNT_W{1'b0}};
            nap_snoop_q <= 1'b0;
        end else if (ce) begin
            if (quiesce_ack) begin
                ack_low_cnt_q <= {`BUS_CNT_W{1'b0}};
                nap_snoop_q <= 1'b0;
            end else if (bus_clk_tick && ack_low_cnt_q != `SNOOP_MIN_BUS_CLOCKS) begin
                ack_low_cnt_q <= ack_low_cnt_q + 1'b1;
            end else if (ack_low_cnt_q == `SNOOP_MIN_BUS_CLOCKS) begin
                nap_snoop_q <= 1'b1;
            end
        end
    end

    always @* begin
        state_d = state_q;
        cnt_d = cnt_q;
        target_sleep_d = target_sleep_q;
        case (state_q)
            ST_FULL_ON: begin
                cnt_d = {`CNT_W{1'b0}};
                // an ambiguous mode selection is ignored
                if (pow_rise && is_one_hot3({sel_sleep, sel_nap, sel_doze})) begin
                    if (sel_doze) begin
                        state_d = ST_DOZE_ENTRY;
                    end else begin
                        state_d = ST_QUIESCE;
                        target_sleep_d = sel_sleep;
                    end
                end
            end
            ST_DOZE_ENTRY: begin
                if (wake_now) begin
                    state_d = ST_FULL_ON;
                end else if (entry_done(cnt_q)) begin
                    state_d = ST_DOZE;
                end else begin
                    cnt_d = entry_step(cnt_q);
                end
            end
            ST_DOZE: begin
                if (wake_now) begin
                    state_d = ST_FULL_ON;
                end
            end
            ST_QUIESCE: begin
                if (wake_now) begin
                    state_d = ST_FULL_ON;
                end else if (quiesce_ack) begin
                    state_d = target_sleep_q ? ST_SLEEP_ENTRY : ST_NAP_ENTRY;
                end
            end
            ST_NAP_ENTRY, ST_SLEEP_ENTRY: begin
                if (wake_now) begin
                    state_d = ST_FULL_ON;
                end else if (entry_done(cnt_q)) begin
                    state_d = (state_q == ST_SLEEP_ENTRY) ? ST_SLEEP : ST_NAP;
                end else begin
                    cnt_d = entry_step(cnt_q);
                end
            end
            ST_NAP: begin
                if (wake_nap) begin
                    state_d = ST_FULL_ON;
                end
            end
            ST_SLEEP: begin
                if (wake_sleep) begin
                    state_d = ST_FULL_ON;
                end
            end
            default: state_d = ST_FULL_ON;
        endcase
    end

    always @(posedge mclk) begin
        if (!reset_n) begin
            state_q <= ST_FULL_ON;
            cnt_q <= {`CNT_W{1'b0}};
            target_sleep_q <= 1'b0;
        end else if (ce) begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            target_sleep_q <= target_sleep_d;
        end
    end

    // state outputs derived from the next state so they follow it with no extra lag
    always @(posedge mclk) begin
        if (!reset_n) begin
            quiesce_request <= 1'b0;
            snoop_enable <= 1'b1;
            timer_enable <= 1'b1;
            dcache_enable <= 1'b1;
            core_run <= 1'b1;
            power_state <= ST_FULL_ON;
        end else if (ce) begin
            power_state <= state_d;
            core_run <= (state_d == ST_FULL_ON);
            quiesce_request <= asks_quiesce(state_d);
            timer_enable <= !in_sleep_group(state_d);
            snoop_enable <= (state_d == ST_FULL_ON) || in_doze_group(state_d) ||
                            (state_d == ST_QUIESCE) ||
                            (in_nap_group(state_d) && nap_snoop_q);
            dcache_enable <= !(in_nap_group(state_d) || in_sleep_group(state_d)) ||
                             (nap_snoop_q && (state_d == ST_NAP));
        end
    end

    unit_clock_gate u_gate (
        .mclk(mclk),
        .reset_n(reset_n),
        .ce(ce),
        .gate_enable(impl_config_reg[`BIT_DYN_GATE]),
        .mode_run(state_d == ST_FULL_ON),
        .unit_demand(unit_demand),
        .unit_clk_en(unit_clk_en)
    );
endmodule

/* File: hw/pwr_mode_map.vh */
// register map, field positions and timing constants of the power mode control block
`ifndef PWR_MODE_MAP_VH
`define PWR_MODE_MAP_VH

`define ADDR_W 4
`define ADDR_IMPL_CONFIG 4'h0
`define ADDR_MACHINE_STATE 4'h1
`define ADDR_STATUS 4'h2
`define ADDR_UNIT_DEMAND 4'h3

`define BIT_DOZE 8
`define BIT_NAP 9
`define BIT_SLEEP 10
`define BIT_DYN_GATE 11
`define BIT_POW 18

`define IMPL_CONFIG_MASK 32'h00000F00
`define MACHINE_STATE_MASK 32'h00040000
`define IMPL_CONFIG_RESET 32'h00000000
`define MACHINE_STATE_RESET 32'h00000000

`define NUM_UNITS 4
`define UNIT_DEMAND_RESET 4'h0

`define ENTRY_DELAY 3'h4
`define CNT_W 3
`define SNOOP_MIN_BUS_CLOCKS 4'h8
`define BUS_CNT_W 4

`endif

/* File: hw/unit_clock_gate.v */
// per unit clock enable generator for automatic power reduction
`timescale 1ns/1ps
`include "pwr_mode_map.vh"

module unit_clock_gate (
    mclk,
    reset_n,
    ce,
    gate_enable,
    mode_run,
    unit_demand,
    unit_clk_en
);
    input wire mclk;
    input wire reset_n;
    input wire ce;
    input wire gate_enable;
    input wire mode_run;
    input wire [`NUM_UNITS-1:0] unit_demand;
    output reg [`NUM_UNITS-1:0] unit_clk_en;

    reg [`NUM_UNITS-1:0] unit_clk_en_d;

    // the enable is registered, so it follows its demand one cycle later and a gated unit
    // waits a cycle for its clock, which makes the gating visible from outside
    always @* begin
        if (!mode_run) begin
            unit_clk_en_d = {`NUM_UNITS{1'b0}};
        end else if (gate_enable) begin
            unit_clk_en_d = unit_demand;
        end else begin
            unit_clk_en_d = {`NUM_UNITS{1'b1}};
        end
    end

    always @(posedge mclk) begin
        if (!reset_n) begin
            unit_clk_en <= {`NUM_UNITS{1'b1}};
        end else if (ce) begin
            unit_clk_en <= unit_clk_en_d;
        end
    end
endmodule
